// [hdl/hmp_host_port.sv]
`timescale 1ns/1ps

// Functional notes
// - non-muxed mode: address from dedicated inputs
// - indirect mode decodes only lowest address input
// - muxed mode ignores dedicated address inputs
// - muxed lines carry address, then data
// - serial mode: bit5 clock, bit6 receive
// - serial mode: bit7 open-drain transmit
// - separate strobes: read strobe reads, write writes
// - data strobe rising edge completes access
// - direction high reads, low writes
// - address latched while latch strobe high
// - latch strobe activity selects muxed operation
// - respond only while chip select low
// - interrupt pin: open-drain low or push-pull
// - reset input low holds reset state
// - addressing select 0 direct, 1 indirect
// - serial command is header, address, data
module hmp_host_port import hmp_pkg::*; (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write channels
    input wire logic [AXI_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read channels
    input wire logic [AXI_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // host bus pins
    input wire logic [7:0] host_address_inputs,
    input wire logic [7:0] shared_bus_in,
    output logic [7:0] shared_bus_out,
    output logic [7:0] shared_bus_oe_n,
    input wire logic rd_n_data_strobe_n,
    input wire logic wr_n_read_write,
    input wire logic ale,
    input wire logic cs_n,
    input wire logic addressing_select,
    input wire logic device_clear_n,
    // host interrupt pin
    output logic host_int_out,
    output logic host_int_oe_n,
    // interrupt to local software
    output logic irq
);

    // ------------------------------------------------------------------
    // pin synchronisers and local reset
    // ------------------------------------------------------------------
    hmp_pins_t pins_raw;
    hmp_pins_t pins;
    logic rst_n;

    assign pins_raw = '{host_address_inputs: host_address_inputs,
                        shared_bus_lines: shared_bus_in,
                        strobe_n: rd_n_data_strobe_n,
                        dir: wr_n_read_write,
                        ale: ale,
                        cs_n: cs_n,
                        addressing_select: addressing_select,
                        device_clear_n: device_clear_n};

    hmp_pin_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pins_raw(pins_raw),
        .pins_sync(pins)
    );

    // pin reset is synchronised, so it acts like the bus reset
    assign rst_n = aresetn & pins.device_clear_n;

    // ------------------------------------------------------------------
    // software state
    // ------------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [7:0] regs_q [REG_NUM];
    logic [7:0] ptr_q;
    logic mux_mode_q;
    logic serial_sel;
    logic dstb_style;

    assign serial_sel = ctrl_q[CTRL_SERIAL_SEL];
    assign dstb_style = ctrl_q[CTRL_DSTB_STYLE];

    // ------------------------------------------------------------------
    // parallel bus decode
    // ------------------------------------------------------------------
    logic cs_act;
    logic rd_strb;
    logic wr_strb;
    logic rd_strb_q;
    logic wr_strb_q;
    logic [7:0] addr_latch_q;
    logic [7:0] acc_addr;
    logic [7:0] acc_addr_q;
    logic [7:0] wr_byte_q;
    logic indirect;
    logic ptr_access;
    logic [REG_IDX_W-1:0] tgt_idx;
    logic host_wr_done;
    logic host_rd_done;

    assign cs_act = ~pins.cs_n & ~serial_sel;
    assign indirect = pins.addressing_select;

    // separate strobes, or one data strobe plus a direction line
    always_comb begin
        if (dstb_style) begin
            rd_strb = cs_act & ~pins.strobe_n & pins.dir;
            wr_strb = cs_act & ~pins.strobe_n & ~pins.dir;
        end else begin
            rd_strb = cs_act & ~pins.strobe_n;
            wr_strb = cs_act & ~pins.dir;
        end
    end

    // dedicated inputs are ignored once the bus runs multiplexed
    assign acc_addr = mux_mode_q ? addr_latch_q
                                 : pins.host_address_inputs;

    // in indirect mode only bit 0 matters; upper inputs sit high
    assign ptr_access = indirect & ~acc_addr_q[0];
    assign tgt_idx = indirect ? ptr_q[REG_IDX_W-1:0]
                              : acc_addr_q[REG_IDX_W-1:0];

    // access completes when the strobe goes away, not when it arrives
    assign host_wr_done = wr_strb_q & ~wr_strb;
    assign host_rd_done = rd_strb_q & ~rd_strb;

    // any latch strobe pulse marks the bus as multiplexed
    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            mux_mode_q <= 1'b0;
        end else if (pins.ale) begin
            mux_mode_q <= 1'b1;
        end
    end

    // address phase on the shared lines while the latch strobe is high
    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            addr_latch_q <= BYTE_RESET;
        end else if (pins.ale && !serial_sel) begin
            addr_latch_q <= pins.shared_bus_lines;
        end
    end

    // strobe history, address and write data held through the access
    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            rd_strb_q <= 1'b0;
            wr_strb_q <= 1'b0;
            acc_addr_q <= BYTE_RESET;
            wr_byte_q <= BYTE_RESET;
        end else begin
            rd_strb_q <= rd_strb;
            wr_strb_q <= wr_strb;
            if (rd_strb || wr_strb) acc_addr_q <= acc_addr;
            if (wr_strb) wr_byte_q <= pins.shared_bus_lines;
        end
    end

    // indirect pointer, loaded by a write with address bit 0 low
    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            ptr_q <= BYTE_RESET;
        end else if (host_wr_done && ptr_access) begin
            ptr_q <= wr_byte_q;
        end
    end

    // ------------------------------------------------------------------
    // serial control interface on shared lines 5..7
    // ------------------------------------------------------------------
    logic ser_en;
    logic [7:0] ser_addr;
    logic [7:0] ser_wdata;
    logic ser_read;
    logic ser_done;
    logic ser_busy;
    logic ser_tx;

    assign ser_en = serial_sel & ~pins.cs_n;

    hmp_serial_engine u_ser (
        .aclk(aclk),
        .rst_n(rst_n),
        .enable(ser_en),
        .ser_clk(pins.shared_bus_lines[SER_CLK_BIT]),
        .ser_rx(pins.shared_bus_lines[SER_RX_BIT]),
        .rd_byte(regs_q[ser_addr[REG_IDX_W-1:0]]),
        .cmd_addr(ser_addr),
        .cmd_wdata(ser_wdata),
        .cmd_read(ser_read),
        .cmd_done(ser_done),
        .busy(ser_busy),
        .ser_tx(ser_tx)
    );

    // ------------------------------------------------------------------
    // shared line drivers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            shared_bus_out <= BYTE_RESET;
            shared_bus_oe_n <= 8'hFF;
        end else if (serial_sel) begin
            // open drain: only ever pull low, release for a one
            shared_bus_out <= BYTE_RESET;
            shared_bus_oe_n <= 8'hFF;
            shared_bus_oe_n[SER_TX_BIT] <= ser_tx;
        end else begin
            shared_bus_out <= ptr_access ? ptr_q : regs_q[tgt_idx];
            shared_bus_oe_n <= {8{~rd_strb}};
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------------
    logic aw_full_q;
    logic w_full_q;
    logic [AXI_AW-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic axi_wr;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_word;
    logic [REG_IDX_W-1:0] wr_ridx;
    logic [REG_IDX_W-1:0] rd_ridx;

    // one outstanding write: hold each channel until the response leaves
    assign awready = ~aw_full_q & ~bvalid;
    assign wready = ~w_full_q & ~bvalid;
    assign axi_wr = aw_full_q & w_full_q & ~bvalid;
    assign arready = ~rvalid;
    assign wr_ridx = aw_addr_q[REG_IDX_W+1:2];
    assign rd_ridx = araddr[REG_IDX_W+1:2];

    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_full_q <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (axi_wr) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // write decode; status is read only and answers okay
    always_comb begin
        case (aw_addr_q)
            OFS_CTRL, OFS_STATUS, OFS_IRQ_STAT, OFS_IRQ_MASK: wr_hit = 1'b1;
            default: wr_hit = (aw_addr_q[7:6] == OFS_REGFILE[7:6]) &&
                              (aw_addr_q[1:0] == 2'b00);
        endcase
    end

    // read decode, unmapped words read zero with an error answer
    always_comb begin
        rd_word = '0;
        rd_hit = 1'b1;
        case (araddr)
            OFS_CTRL: rd_word[CTRL_W-1:0] = ctrl_q;
            OFS_STATUS: begin
                rd_word[STAT_MUX_MODE] = mux_mode_q;
                rd_word[STAT_INDIRECT] = indirect;
                rd_word[STAT_SER_BUSY] = ser_busy;
                rd_word[STAT_PTR_LSB +: 8] = ptr_q;
                rd_word[STAT_LAST_ADDR_LSB +: 8] = acc_addr_q;
            end
            OFS_IRQ_STAT: rd_word[IRQ_W-1:0] = irq_stat_q;
            OFS_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask_q;
            default: begin
                rd_hit = (araddr[7:6] == OFS_REGFILE[7:6]) &&
                         (araddr[1:0] == 2'b00);
                if (rd_hit) rd_word[7:0] = regs_q[rd_ridx];
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // control, mask and register file writes
    // ------------------------------------------------------------------
    logic sw_wr_ok;

    assign sw_wr_ok = axi_wr & wr_hit & w_strb_q[0];

    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RESET;
            irq_mask_q <= IRQ_RESET;
        end else if (sw_wr_ok) begin
            if (aw_addr_q == OFS_CTRL) ctrl_q <= w_data_q[CTRL_W-1:0];
            if (aw_addr_q == OFS_IRQ_MASK) irq_mask_q <= w_data_q[IRQ_W-1:0];
        end
    end

    // host side writes land last, so they win a same-cycle collision
    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            for (int i = 0; i < REG_NUM; i++) regs_q[i] <= BYTE_RESET;
        end else begin
            if (sw_wr_ok && aw_addr_q[7:6] == OFS_REGFILE[7:6]) begin
                regs_q[wr_ridx] <= w_data_q[7:0];
            end
            if (host_wr_done && !ptr_access) begin
                regs_q[tgt_idx] <= wr_byte_q;
            end
            if (ser_done && !ser_read) begin
                regs_q[ser_addr[REG_IDX_W-1:0]] <= ser_wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // event flags and interrupts
    // ------------------------------------------------------------------
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;

    assign irq_set = {ser_done, host_rd_done, host_wr_done};
    assign irq_clr = (sw_wr_ok && aw_addr_q == OFS_IRQ_STAT) ?
                     w_data_q[IRQ_W-1:0] : IRQ_RESET;

    // write one to clear; a new event in the same cycle stays set
    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            irq_stat_q <= IRQ_RESET;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // host pin: released low-active open drain unless push-pull chosen
    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            host_int_out <= 1'b0;
            host_int_oe_n <= 1'b1;
        end else if (ctrl_q[CTRL_INT_PUSH_PULL]) begin
            host_int_out <= ctrl_q[CTRL_HOST_INT_REQ];
            host_int_oe_n <= 1'b0;
        end else begin
            host_int_out <= 1'b0;
            host_int_oe_n <= ~ctrl_q[CTRL_HOST_INT_REQ];
        end
    end

endmodule // hmp_host_port

// [hdl/hmp_pkg.sv]
package hmp_pkg;

    // --------------------------------------------------------------
    // register map (byte addresses on the register bus)
    // --------------------------------------------------------------
    localparam int AXI_AW = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFS_REGFILE = 8'h40;
    localparam int REG_NUM = 16;
    localparam int REG_IDX_W = 4;

    // --------------------------------------------------------------
    // control register fields
    // --------------------------------------------------------------
    localparam int CTRL_SERIAL_SEL = 0;
    localparam int CTRL_DSTB_STYLE = 1;
    localparam int CTRL_INT_PUSH_PULL = 2;
    localparam int CTRL_HOST_INT_REQ = 3;
    localparam int CTRL_W = 4;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // --------------------------------------------------------------
    // status and interrupt fields
    // --------------------------------------------------------------
    localparam int STAT_MUX_MODE = 0;
    localparam int STAT_INDIRECT = 1;
    localparam int STAT_SER_BUSY = 2;
    localparam int STAT_PTR_LSB = 8;
    localparam int STAT_LAST_ADDR_LSB = 16;
    localparam int IRQ_HOST_WR = 0;
    localparam int IRQ_HOST_RD = 1;
    localparam int IRQ_SER_CMD = 2;
    localparam int IRQ_W = 3;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // --------------------------------------------------------------
    // bus answers, serial framing, shared line positions
    // --------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam int SER_CLK_BIT = 5;
    localparam int SER_RX_BIT = 6;
    localparam int SER_TX_BIT = 7;
    localparam logic [4:0] SER_HDR_LAST = 5'd7;
    localparam logic [4:0] SER_ADDR_LAST = 5'd15;
    localparam logic [4:0] SER_DATA_FIRST = 5'd16;
    localparam logic [4:0] SER_DATA_LAST = 5'd23;
    localparam int SER_HDR_READ = 7;

    // host pin bundle, as seen before and after synchronising
    typedef struct packed {
        logic [7:0] host_address_inputs;
        logic [7:0] shared_bus_lines;
        logic strobe_n;
        logic dir;
        logic ale;
        logic cs_n;
        logic addressing_select;
        logic device_clear_n;
    } hmp_pins_t;

endpackage

// [hdl/hmp_pin_sync.sv]
`timescale 1ns/1ps
module hmp_pin_sync import hmp_pkg::*; (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pins in, synchronised pins out
    input wire hmp_pins_t pins_raw,
    output hmp_pins_t pins_sync
);

    hmp_pins_t meta_q;
    hmp_pins_t sync_q;

    // two flops; only the second stage is visible to the block
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '1;
            sync_q <= '1;
            meta_q.ale <= 1'b0; // latch strobe idles low
            sync_q.ale <= 1'b0;
        end else begin
            meta_q <= pins_raw;
            sync_q <= meta_q;
        end
    end

    assign pins_sync = sync_q;

endmodule // hmp_pin_sync

// [hdl/hmp_serial_engine.sv]
`timescale 1ns/1ps
module hmp_serial_engine import hmp_pkg::*; (
    // clock and reset
    input wire logic aclk,
    input wire logic rst_n,
    // synchronised serial lines
    input wire logic enable,
    input wire logic ser_clk,
    input wire logic ser_rx,
    // register file port
    input wire logic [7:0] rd_byte,
    output logic [7:0] cmd_addr,
    output logic [7:0] cmd_wdata,
    output logic cmd_read,
    output logic cmd_done,
    output logic busy,
    // transmit bit, 1 means line released
    output logic ser_tx
);

    logic ser_clk_q;
    logic [4:0] cnt_q;
    logic [7:0] in_sr_q;
    logic [7:0] out_sr_q;
    logic [7:0] hdr_q;
    logic rise;
    logic fall;

    assign rise = ser_clk & ~ser_clk_q;
    assign fall = ~ser_clk & ser_clk_q;
    assign cmd_read = hdr_q[SER_HDR_READ];
    assign busy = enable && (cnt_q != 5'd0);

    // header, address and data bytes, msb first, sampled on rising clock
    always_ff @(posedge aclk) begin
        if (!rst_n || !enable) begin
            ser_clk_q <= ser_clk; // no false rise
            cnt_q <= 5'd0;
            in_sr_q <= BYTE_RESET;
            hdr_q <= BYTE_RESET;
            cmd_addr <= BYTE_RESET;
            cmd_wdata <= BYTE_RESET;
            cmd_done <= 1'b0;
        end else begin
            ser_clk_q <= ser_clk;
            cmd_done <= 1'b0;
            if (rise) begin
                in_sr_q <= {in_sr_q[6:0], ser_rx};
                cnt_q <= (cnt_q == SER_DATA_LAST) ? 5'd0 : cnt_q + 5'd1;
                if (cnt_q == SER_HDR_LAST) hdr_q <= {in_sr_q[6:0], ser_rx};
                if (cnt_q == SER_ADDR_LAST) cmd_addr <= {in_sr_q[6:0], ser_rx};
                if (cnt_q == SER_DATA_LAST) begin
                    cmd_wdata <= {in_sr_q[6:0], ser_rx};
                    cmd_done <= 1'b1;
                end
            end
        end
    end

    // read data leaves on falling clock during the data byte only
    always_ff @(posedge aclk) begin
        if (!rst_n || !enable) begin
            out_sr_q <= BYTE_RESET;
            ser_tx <= 1'b1;
        end else if (fall && cmd_read && cnt_q >= SER_DATA_FIRST) begin
            if (cnt_q == SER_DATA_FIRST) begin
                ser_tx <= rd_byte[7];
                out_sr_q <= {rd_byte[6:0], 1'b1};
            end else begin
                ser_tx <= out_sr_q[7];
                out_sr_q <= {out_sr_q[6:0], 1'b1};
            end
        end else if (cnt_q == 5'd0) begin
            ser_tx <= 1'b1;
        end
    end

endmodule // hmp_serial_engine

// [sim/hmp_host_port_monitor.sv]
`timescale 1ns/1ps
// ----
// bus and pin checks at the port
// ----
module hmp_host_port_monitor import hmp_pkg::*; (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [AXI_AW-1:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    // host pins
    input wire logic [7:0] shared_bus_oe_n,
    input wire logic rd_n_data_strobe_n,
    input wire logic cs_n,
    input wire logic device_clear_n,
    input wire logic host_int_oe_n
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // answers must stand until the master takes them
    a_write_resp_held: assert property (bvalid && !bready |=> bvalid)
        else $error("write answer dropped early");
    a_read_resp_held: assert property (rvalid && !rready |=>
        rvalid && $stable(rdata)) else $error("read answer changed early");
    a_read_latency: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    a_unmapped_error: assert property (arvalid && arready && araddr ==
        8'h10 |=> rresp == RESP_SLVERR && rdata == 32'h0)
        else $error("unmapped read not refused");
    // parallel lines are driven as one byte, never split
    a_lines_together: assert property (
        shared_bus_oe_n[6:0] == {7{shared_bus_oe_n[0]}})
        else $error("shared lines split");
    a_deselect_release: assert property (
        cs_n [*6] |-> shared_bus_oe_n == 8'hff)
        else $error("lines driven while deselected");
    a_drive_cause: assert property (
        $fell(shared_bus_oe_n[0]) |-> $past(!rd_n_data_strobe_n && !cs_n, 2))
        else $error("lines driven without read strobe");
    a_pin_clear: assert property (
        !device_clear_n [*4] |=> shared_bus_oe_n == 8'hff && host_int_oe_n)
        else $error("pins active during pin reset");
endmodule // hmp_host_port_monitor

bind hmp_host_port hmp_host_port_monitor i_hmp_host_port_monitor (.aclk,
    .aresetn, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .shared_bus_oe_n, .rd_n_data_strobe_n,
    .cs_n, .device_clear_n, .host_int_oe_n);

// [sim/hmp_host_model.sv]
`timescale 1ns/1ps
// ----
// host microcontroller on the pin side
// ----
module hmp_host_model (
    // clock
    input wire logic aclk,
    // device side of the shared lines
    input wire logic [7:0] dev_out,
    input wire logic [7:0] dev_oe_n,
    // host pins
    output logic [7:0] addr,
    output wire logic [7:0] line,
    output logic rd_n,
    output logic wr_n,
    output logic ale,
    output logic cs_n,
    output logic asel,
    output logic clear_n
);
    logic [7:0] drv = 8'h00;
    logic en = 1'b0;
    bit dstb, mux, sel = 1'b1;
    // no pull on these lines: a released line shows the inverse value
    assign line = (~dev_oe_n & dev_out) | (dev_oe_n & (en ? drv : ~drv));
    initial begin
        {addr, rd_n, wr_n, ale, cs_n, asel, clear_n} = {8'hff, 6'h35};
    end
    // one access, strobe held six cycles (a separate write strobe seven) so the synchroniser sees it
    task automatic acc(input bit wr, input logic [7:0] a, d,
                       output logic [7:0] q);
        @(posedge aclk);
        cs_n <= !sel;
        addr <= mux ? 8'hff : a;
        if (mux) begin
            ale <= 1'b1;
            drv <= a;
            en <= 1'b1;
            repeat (4) @(posedge aclk);
            ale <= 1'b0;
        end
        drv <= d;
        en <= wr;
        rd_n <= dstb ? 1'b0 : wr;
        wr_n <= !wr;
        repeat (6) @(posedge aclk);
        q = line;
        rd_n <= 1'b1;
        @(posedge aclk);
        {cs_n, wr_n, en} <= 3'b110;
        repeat (3) @(posedge aclk);
    endtask
endmodule // hmp_host_model

// [sim/hmp_host_port_tb_top.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
    $display("mismatch %0t %h %h", $time, a, b); end end
module hmp_host_port_tb_top import hmp_pkg::*; ;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
    logic irq, int_out, int_oe_n, rd_n, wr_n, ale, cs_n, asel, clear_n;
    logic [7:0] awaddr = 0, araddr = 0, haddr, bus_out, bus_oe_n, q;
    wire [7:0] line;
    logic [31:0] wdata = 0, rdata, scmd = 32'h0000_0a96;
    logic [1:0] bresp, rresp;
    logic [9:0] ic [4] = '{10'h020, 10'h031, 10'h010, 10'h002};
    int miscompares = 0, compares = 0;
    hmp_host_port i_hmp_host_port (.aclk, .aresetn, .awaddr, .awvalid,
        .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .host_address_inputs(haddr), .shared_bus_in(line),
        .shared_bus_out(bus_out), .shared_bus_oe_n(bus_oe_n),
        .rd_n_data_strobe_n(rd_n), .wr_n_read_write(wr_n), .ale, .cs_n,
        .addressing_select(asel), .device_clear_n(clear_n),
        .host_int_out(int_out), .host_int_oe_n(int_oe_n), .irq);
    hmp_host_model i_hmp_host_model (.aclk, .dev_out(bus_out),
        .dev_oe_n(bus_oe_n), .addr(haddr), .line, .rd_n, .wr_n, .ale,
        .cs_n, .asel, .clear_n);
    initial forever #2 aclk = ~aclk;
    // ----
    // register bus master
    // ----
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        `CHK(bresp, er)
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] er);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        `CHK(rdata, e)
        `CHK(rresp, er)
    endtask
    task automatic final_report();
        if (miscompares == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        axr(OFS_CTRL, 32'h0, RESP_OKAY);
        axr(OFS_IRQ_STAT, 32'h0, RESP_OKAY);
        axr(8'h10, 32'h0, RESP_SLVERR);
        axw(8'h10, 32'h1, RESP_SLVERR);
        axw(OFS_IRQ_MASK, 32'h1, RESP_OKAY);
        i_hmp_host_model.acc(1'b1, 8'h03, 8'h5a, q);
        axr(OFS_REGFILE + 8'd12, 32'h5a, RESP_OKAY);
        `CHK(irq, 1'b1)
        i_hmp_host_model.acc(1'b0, 8'h03, 8'h00, q);
        `CHK(q, 8'h5a)
        axr(OFS_IRQ_STAT, 32'h3, RESP_OKAY);
        axw(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b0)
        axr(OFS_IRQ_STAT, 32'h2, RESP_OKAY);
        // a deselected write must leave the byte alone
        i_hmp_host_model.sel = 1'b0;
        i_hmp_host_model.acc(1'b1, 8'h03, 8'hff, q);
        i_hmp_host_model.sel = 1'b1;
        axr(OFS_REGFILE + 8'd12, 32'h5a, RESP_OKAY);
        axw(OFS_CTRL, 32'h2, RESP_OKAY);
        i_hmp_host_model.dstb = 1'b1;
        i_hmp_host_model.acc(1'b1, 8'h05, 8'ha6, q);
        i_hmp_host_model.acc(1'b0, 8'h05, 8'h00, q);
        `CHK(q, 8'ha6)
        i_hmp_host_model.asel <= 1'b1;
        i_hmp_host_model.acc(1'b1, 8'hfe, 8'h07, q);
        i_hmp_host_model.acc(1'b1, 8'hff, 8'hc3, q);
        axr(OFS_REGFILE + 8'd28, 32'hc3, RESP_OKAY);
        i_hmp_host_model.asel <= 1'b0;
        axw(OFS_CTRL, 32'h1, RESP_OKAY);
        i_hmp_host_model.cs_n <= 1'b0;
        for (int i = 47; i >= 0; i--) begin
            i_hmp_host_model.drv <= ~{1'b0, scmd[i/2], ~i[0], 5'h0};
            repeat (4) @(posedge aclk);
        end
        i_hmp_host_model.cs_n <= 1'b1;
        axr(OFS_REGFILE + 8'd40, 32'h96, RESP_OKAY);
        // interrupt pin drive for each drive mode and request level
        foreach (ic[i]) begin
            axw(OFS_CTRL, {24'h00_0000, ic[i][9:2]}, RESP_OKAY);
            repeat (2) @(posedge aclk);
            `CHK({int_oe_n, int_out}, ic[i][1:0])
        end
        i_hmp_host_model.dstb = 1'b0;
        i_hmp_host_model.mux = 1'b1;
        i_hmp_host_model.acc(1'b1, 8'h09, 8'h3c, q);
        axr(OFS_REGFILE + 8'd36, 32'h3c, RESP_OKAY);
        axr(OFS_STATUS, 32'h0009_0701, RESP_OKAY);
        i_hmp_host_model.mux = 1'b0;
        i_hmp_host_model.clear_n <= 1'b0;
        repeat (6) @(posedge aclk);
        i_hmp_host_model.clear_n <= 1'b1;
        repeat (4) @(posedge aclk);
        axr(OFS_STATUS, 32'h0, RESP_OKAY);
        final_report();
    end
    initial begin
        #100000;
        miscompares++;
        final_report();
    end
endmodule // hmp_host_port_tb_top
